// *** hw/acms_params.svh ***
// constants and rule notes for the conversion mode sequencer
// Notes on behaviour
// - commands act at eighth falling serial edge
// - first conversion starts 28.5 oscillator periods later (code: continuous mode only; single-shot converts at once)
// - continuous spacing 51192/11532/3116/1036 periods
// - single-shot latency 51213/11557/3141/1061 periods
// - resets: power-on, pin, command
// - reset restores defaults, idles, awaits start
// - power-on reset held about 500 us
// - opcodes 06h and 07h reset device
// - general-call software reset equals reset command
// - single-shot: one conversion then low power
// - single-shot config write restarts one conversion
// - continuous: store result, start next immediately
// - continuous config write restarts conversion
// - sleep finishes current conversion first
// - sleep keeps config, decodes, never converts
// - start wakes from sleep per mode bit
// - ready low on new result, high when latched
// - general call then 06h resets
`ifndef ACMS_PARAMS_SVH
`define ACMS_PARAMS_SVH
`define ACMS_SYS_CLK_KHZ     125000
`define ACMS_OSC_KHZ         1024
// oscillator tick every 125000/1024 = 122.07 cycles: fractional accumulator
`define ACMS_OSC_ACC_W       17
`define ACMS_OSC_ACC_INC     17'h00400
`define ACMS_OSC_ACC_MOD     17'h1E848
// half-oscillator ticks: the 28.5 period start delay needs half resolution
`define ACMS_START_HALF      17'h00039
`define ACMS_CONT_20         17'h0C7F8
`define ACMS_CONT_90         17'h02D0C
`define ACMS_CONT_330        17'h00C2C
`define ACMS_CONT_1000       17'h0040C
`define ACMS_SINGLE_20       17'h0C80D
`define ACMS_SINGLE_90       17'h02D25
`define ACMS_SINGLE_330      17'h00C45
`define ACMS_SINGLE_1000     17'h00425
`define ACMS_OPC_RESET_A     8'h06
`define ACMS_OPC_RESET_B     8'h07
`define ACMS_OPC_START_A     8'h08
`define ACMS_OPC_START_B     8'h09
`define ACMS_OPC_SLEEP_A     8'h02
`define ACMS_OPC_SLEEP_B     8'h03
`define ACMS_GC_RESET        8'h06
`define ACMS_POR_US          500
`define ACMS_POR_CYCLES      (`ACMS_POR_US * (`ACMS_SYS_CLK_KHZ / 1000))
`define ACMS_CNT_W           17
`define ACMS_DATA_W          24
`define ACMS_READY_MIN_HIGH  8'h02
`endif

// *** hw/acms_pkg.sv ***
// types for the conversion mode sequencer
package acms_pkg;
  typedef enum logic [1:0] {
    ACMS_RATE_20,
    ACMS_RATE_90,
    ACMS_RATE_330,
    ACMS_RATE_1000
  } acms_rate_t;

  typedef enum logic [2:0] {
    ACMS_CMD_NONE,
    ACMS_CMD_START,
    ACMS_CMD_SLEEP,
    ACMS_CMD_RESET,
    ACMS_CMD_CFG_WRITE
  } acms_cmd_t;

  typedef enum {
    ACMS_ST_IDLE,
    ACMS_ST_DELAY,
    ACMS_ST_CONVERT
  } acms_state_t;

  // decoded command strobe, taken on the eighth falling serial edge
  typedef struct packed {
    logic            valid;
    logic [7:0]      opcode;
    logic            general_call;
    logic            cfg_write;
  } acms_cmd_in_t;
endpackage

// *** hw/acms_osc_tick.sv ***
// oscillator rate divider: one-cycle enable at twice the 1.024 MHz rate
`timescale 1ns/1ps
`default_nettype none
`include "acms_params.svh"
module acms_osc_tick #(
  parameter int SPEEDUP = 1
) (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic reset_i,
  // control
  input  wire logic run_i,
  output logic      half_tick_o
);
  logic [`ACMS_OSC_ACC_W-1:0] acc_r;
  logic [`ACMS_OSC_ACC_W-1:0] acc_nxt;
  logic                       tick_nxt;
  logic [`ACMS_OSC_ACC_W:0]   acc_sum;

  // step per cycle; a speed-up above one only shortens simulation and must keep the step below the modulus
  localparam logic [`ACMS_OSC_ACC_W:0] STEP = (`ACMS_OSC_ACC_W + 1)'(`ACMS_OSC_ACC_INC * 2 * SPEEDUP);

  // fractional accumulator keeps long-term rate exact; one spare bit keeps the sum from wrapping
  always_comb begin
    acc_sum  = {1'b0, acc_r} + STEP;
    acc_nxt  = acc_r;
    tick_nxt = 1'b0;
    if (!run_i) begin
      acc_nxt = '0;
    end else if (acc_sum >= {1'b0, `ACMS_OSC_ACC_MOD}) begin
      acc_nxt  = `ACMS_OSC_ACC_W'(acc_sum - {1'b0, `ACMS_OSC_ACC_MOD});
      tick_nxt = 1'b1;
    end else begin
      acc_nxt = `ACMS_OSC_ACC_W'(acc_sum);
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      acc_r       <= '0;
      half_tick_o <= 1'b0;
    end else begin
      acc_r       <= acc_nxt;
      half_tick_o <= tick_nxt;
    end
  end
endmodule
`default_nettype wire

// *** hw/acms_sequencer.sv ***
// conversion mode sequencer: resets, modes, commands and conversion timing
`timescale 1ns/1ps
`default_nettype none
`include "acms_params.svh"
module acms_sequencer #(
  parameter int POR_CYCLES  = `ACMS_POR_CYCLES,
  parameter int OSC_SPEEDUP = 1
) (
  // clock and reset
  input  wire logic                    sys_clk_i,
  input  wire logic                    reset_i,
  input  wire logic                    reset_pin_n_i,
  // command strobe from the serial front end
  input  wire acms_pkg::acms_cmd_in_t  cmd_i,
  input  wire logic                    cfg_mode_i,
  input  wire logic [1:0]              cfg_rate_i,
  // converter core
  input  wire logic [`ACMS_DATA_W-1:0] core_result_i,
  input  wire logic                    result_latch_i,
  // status and data
  output logic                         result_ready_n_o,
  output logic                         result_ready_oe_o,
  output logic [`ACMS_DATA_W-1:0]      result_data_o,
  output logic                         cfg_defaults_o,
  output logic                         analog_on_o,
  output logic                         converting_o,
  output logic                         conversion_mode_sel_o,
  output logic                         sleep_mode_o
);
  // conversion length in half oscillator ticks
  function automatic logic [`ACMS_CNT_W-1:0] conv_len(input logic single, input logic [1:0] rate);
    logic [`ACMS_CNT_W-1:0] p;
    p = '0;
    case (rate)
      2'h0:    p = single ? `ACMS_SINGLE_20   : `ACMS_CONT_20;
      2'h1:    p = single ? `ACMS_SINGLE_90   : `ACMS_CONT_90;
      2'h2:    p = single ? `ACMS_SINGLE_330  : `ACMS_CONT_330;
      default: p = single ? `ACMS_SINGLE_1000 : `ACMS_CONT_1000;
    endcase
    return `ACMS_CNT_W'({p, 1'b0});
  endfunction

  // power-on reset stretch
  logic [31:0] por_cnt_r;
  logic [31:0] por_cnt_nxt;
  logic        por_busy;
  always_comb begin
    por_cnt_nxt = por_cnt_r;
    if (por_cnt_r == 32'hFFFFFFFF) begin
      por_cnt_nxt = 32'(POR_CYCLES);  // first edge after release loads the stretch
    end else if (por_cnt_r != 32'h0) begin
      por_cnt_nxt = por_cnt_r - 32'h1;
    end
  end
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      por_cnt_r <= 32'hFFFFFFFF;
    end else begin
      por_cnt_r <= por_cnt_nxt;
    end
  end
  assign por_busy = (por_cnt_r != 32'h0);

  // command decode; any reset source acts alike
  logic cmd_reset;
  logic cmd_start;
  logic cmd_sleep;
  logic soft_reset;
  assign cmd_reset = cmd_i.valid && !cmd_i.general_call && !cmd_i.cfg_write &&
                     (cmd_i.opcode == `ACMS_OPC_RESET_A || cmd_i.opcode == `ACMS_OPC_RESET_B);
  assign soft_reset = cmd_reset ||
                      (cmd_i.valid && cmd_i.general_call && cmd_i.opcode == `ACMS_GC_RESET);
  assign cmd_start = cmd_i.valid && !cmd_i.general_call && !cmd_i.cfg_write &&
                     (cmd_i.opcode == `ACMS_OPC_START_A || cmd_i.opcode == `ACMS_OPC_START_B);
  assign cmd_sleep = cmd_i.valid && !cmd_i.general_call && !cmd_i.cfg_write &&
                     (cmd_i.opcode == `ACMS_OPC_SLEEP_A || cmd_i.opcode == `ACMS_OPC_SLEEP_B);
  logic any_reset;
  assign any_reset = por_busy || !reset_pin_n_i || soft_reset;

  // sequencer state
  acms_pkg::acms_state_t  st_r, st_nxt;
  logic [`ACMS_CNT_W-1:0] cnt_r, cnt_nxt;
  logic                   mode_r, mode_nxt;
  logic                   sleep_pend_r, sleep_pend_nxt;
  logic                   asleep_r, asleep_nxt;
  logic                   done_r, done_nxt;
  logic                   half_tick;
  logic                   restart;

  acms_osc_tick #(
    .SPEEDUP (OSC_SPEEDUP)
  ) u_osc (
    .sys_clk_i   (sys_clk_i),
    .reset_i     (reset_i),
    .run_i       (st_r != acms_pkg::ACMS_ST_IDLE),
    .half_tick_o (half_tick)
  );

  // a config write mid-conversion acts as a fresh start
  assign restart = cmd_start ||
                   (cmd_i.valid && cmd_i.cfg_write && st_r != acms_pkg::ACMS_ST_IDLE);

  always_comb begin
    st_nxt         = st_r;
    cnt_nxt        = cnt_r;
    mode_nxt       = mode_r;
    sleep_pend_nxt = sleep_pend_r;
    asleep_nxt     = asleep_r;
    done_nxt       = 1'b0;
    if (any_reset) begin
      st_nxt         = acms_pkg::ACMS_ST_IDLE;
      cnt_nxt        = '0;
      mode_nxt       = 1'b0;
      sleep_pend_nxt = 1'b0;
      asleep_nxt     = 1'b0;
    end else if (restart) begin
      // mode bit sampled only at start, so host must restart after change
      mode_nxt       = cfg_mode_i;
      asleep_nxt     = 1'b0;
      sleep_pend_nxt = 1'b0;
      if (cfg_mode_i) begin
        st_nxt  = acms_pkg::ACMS_ST_DELAY;
        // the count runs down to zero inclusive, so one less gives exactly 28.5 periods
        cnt_nxt = `ACMS_START_HALF - `ACMS_CNT_W'(1);
      end else begin
        st_nxt  = acms_pkg::ACMS_ST_CONVERT;
        cnt_nxt = conv_len(1'b1, cfg_rate_i) - `ACMS_CNT_W'(1);
      end
    end else begin
      if (cmd_sleep) begin
        if (st_r == acms_pkg::ACMS_ST_IDLE) begin
          asleep_nxt = 1'b1;
        end else begin
          sleep_pend_nxt = 1'b1;
        end
      end
      case (st_r)
        acms_pkg::ACMS_ST_IDLE: begin
          cnt_nxt = '0;
        end
        acms_pkg::ACMS_ST_DELAY: begin
          if (half_tick) begin
            if (cnt_r == '0) begin
              st_nxt  = acms_pkg::ACMS_ST_CONVERT;
              cnt_nxt = conv_len(1'b0, cfg_rate_i) - `ACMS_CNT_W'(1);
            end else begin
              cnt_nxt = cnt_r - `ACMS_CNT_W'(1);
            end
          end
        end
        acms_pkg::ACMS_ST_CONVERT: begin
          if (half_tick) begin
            if (cnt_r == '0) begin
              done_nxt = 1'b1;
              if (!mode_r || sleep_pend_r || cmd_sleep) begin
                st_nxt         = acms_pkg::ACMS_ST_IDLE;
                asleep_nxt     = sleep_pend_r || cmd_sleep;
                sleep_pend_nxt = 1'b0;
              end else begin
                cnt_nxt = conv_len(1'b0, cfg_rate_i) - `ACMS_CNT_W'(1);
              end
            end else begin
              cnt_nxt = cnt_r - `ACMS_CNT_W'(1);
            end
          end
        end
        default: begin
          st_nxt = acms_pkg::ACMS_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_r         <= acms_pkg::ACMS_ST_IDLE;
      cnt_r        <= '0;
      mode_r       <= 1'b0;
      sleep_pend_r <= 1'b0;
      asleep_r     <= 1'b0;
      done_r       <= 1'b0;
    end else begin
      st_r         <= st_nxt;
      cnt_r        <= cnt_nxt;
      mode_r       <= mode_nxt;
      sleep_pend_r <= sleep_pend_nxt;
      asleep_r     <= asleep_nxt;
      done_r       <= done_nxt;
    end
  end

  // output buffer and ready flag; new result wins over a same-cycle latch
  logic [`ACMS_DATA_W-1:0] data_nxt;
  logic                    ready_n_nxt;
  always_comb begin
    data_nxt    = result_data_o;
    ready_n_nxt = result_ready_n_o;
    if (any_reset) begin
      ready_n_nxt = 1'b1;
    end else if (done_r) begin
      data_nxt    = core_result_i;
      ready_n_nxt = 1'b0;
    end else if (result_latch_i) begin
      ready_n_nxt = 1'b1;
    end
  end

  // status outputs registered so every port comes from a flop
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      result_data_o         <= '0;
      result_ready_n_o      <= 1'b1;
      result_ready_oe_o     <= 1'b0;
      cfg_defaults_o        <= 1'b1;
      analog_on_o           <= 1'b0;
      converting_o          <= 1'b0;
      conversion_mode_sel_o <= 1'b0;
      sleep_mode_o          <= 1'b0;
    end else begin
      result_data_o         <= data_nxt;
      result_ready_n_o      <= ready_n_nxt;
      result_ready_oe_o     <= !ready_n_nxt;  // open drain: drive only low
      cfg_defaults_o        <= any_reset;
      analog_on_o           <= st_nxt != acms_pkg::ACMS_ST_IDLE;
      converting_o          <= st_nxt == acms_pkg::ACMS_ST_CONVERT;
      conversion_mode_sel_o <= mode_nxt;
      sleep_mode_o          <= asleep_nxt;
    end
  end
endmodule
`default_nettype wire

// *** test/acms_sequencer_props.sv ***
// checker: port-level properties of the conversion mode sequencer
`timescale 1ns/1ps
`default_nettype none
`include "acms_params.svh"
module acms_sequencer_props #(
  parameter int POR_CYCLES = 20
) (
  // clock, resets and commands
  input wire logic                    sys_clk_i,
  input wire logic                    reset_i,
  input wire logic                    reset_pin_n_i,
  input wire acms_pkg::acms_cmd_in_t  cmd_i,
  input wire logic                    cfg_mode_i,
  input wire logic [1:0]              cfg_rate_i,
  input wire logic [`ACMS_DATA_W-1:0] core_result_i,
  input wire logic                    result_latch_i,
  // outputs watched
  input wire logic                    result_ready_n_o,
  input wire logic                    result_ready_oe_o,
  input wire logic [`ACMS_DATA_W-1:0] result_data_o,
  input wire logic                    cfg_defaults_o,
  input wire logic                    analog_on_o,
  input wire logic                    converting_o,
  input wire logic                    conversion_mode_sel_o,
  input wire logic                    sleep_mode_o
);
  int unsigned por_cnt;

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  // length of the current defaults phase; a stuck stretch would block every command
  always_ff @(posedge sys_clk_i or posedge reset_i)
    if (reset_i) por_cnt <= 0;
    else por_cnt <= cfg_defaults_o ? por_cnt + 1 : 0;

  a_por_hold: assert property ($fell(reset_i) |-> cfg_defaults_o [*8])
    else $error("defaults phase ended too early after reset");
  a_por_bound: assert property (cfg_defaults_o |-> por_cnt <= POR_CYCLES + 2)
    else $error("defaults phase lasted too long");
  a_ready_oe_pair: assert property (result_ready_oe_o == !result_ready_n_o)
    else $error("ready enable disagrees with ready level");
  a_data_when_ready: assert property ($changed(result_data_o) |-> !result_ready_n_o)
    else $error("result buffer changed without ready");
  a_cmd_reset_idle: assert property (cmd_i.valid && !cmd_i.cfg_write && !cfg_defaults_o &&
    (cmd_i.opcode == 8'h06 || (cmd_i.opcode == 8'h07 && !cmd_i.general_call))
    |=> cfg_defaults_o && !converting_o && !analog_on_o && !sleep_mode_o)
    else $error("reset command did not idle the sequencer");
  a_start_wakes: assert property (cmd_i.valid && !cfg_defaults_o && reset_pin_n_i && !cmd_i.general_call
    && !cmd_i.cfg_write && cmd_i.opcode[7:1] == 7'h04 |=> analog_on_o && !sleep_mode_o
    && conversion_mode_sel_o == $past(cfg_mode_i))
    else $error("start command did not begin conversion in chosen mode");
  a_sleep_idle: assert property (sleep_mode_o |-> !converting_o && !analog_on_o)
    else $error("conversion activity while asleep");
  a_pin_reset_idle: assert property (!reset_pin_n_i |=> cfg_defaults_o && !converting_o && !analog_on_o)
    else $error("reset pin did not idle the sequencer");
  a_single_powers_off: assert property ($fell(result_ready_n_o) && !conversion_mode_sel_o |-> !analog_on_o)
    else $error("single conversion left analog powered");
  a_latch_release: assert property (result_latch_i && !result_ready_n_o && !converting_o |=> result_ready_n_o)
    else $error("ready not released after latch");
endmodule
`default_nettype wire

// *** test/acms_host_model.sv ***
// host-side model: command strobes and result reads toward the sequencer
`timescale 1ns/1ps
`default_nettype none
module acms_host_model (
  // clock and ready line
  input  wire logic             sys_clk_i,
  input  wire logic             result_ready_n_i,
  // read pacing, 8'hFF leaves results unread
  input  wire logic [7:0]       read_dly_i,
  // toward the sequencer
  output var acms_pkg::acms_cmd_in_t cmd_o,
  output var logic              result_latch_o
);
  int wait_cnt;

  initial begin
    cmd_o = '0;
    result_latch_o = 1'b0;
    wait_cnt = 0;
  end

  // read a finished result some cycles after ready falls, slow or prompt
  always @(posedge sys_clk_i) begin
    #1;
    result_latch_o = 1'b0;
    if (result_ready_n_i !== 1'b0 || read_dly_i == 8'hFF) wait_cnt = 0;
    else if (wait_cnt++ == read_dly_i) result_latch_o = 1'b1;
  end

  // one command strobe as the serial front end hands it over
  task automatic send(input logic [7:0] op, input logic gc, input logic cw);
    @(posedge sys_clk_i);
    #1;
    cmd_o = '{valid: 1'b1, opcode: op, general_call: gc, cfg_write: cw};
    @(posedge sys_clk_i);
    #1;
    cmd_o = '0;
  endtask
endmodule
`default_nettype wire

// *** test/acms_sequencer_tb_top.sv ***
// testbench top: sequencer with host model, scenario tasks and verdict
`timescale 1ns/1ps
`default_nettype none
`include "acms_params.svh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin error_cnt++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end
module acms_sequencer_tb_top;
  localparam int POR = 20;
  // oscillator sped up in simulation so whole conversions fit the run
  localparam int SPD = 32;
  logic sys_clk_i, reset_i, reset_pin_n_i, cfg_mode_i, latch, rdy_n, oe, dflt, aon, conv, msel, slp;
  logic [1:0] cfg_rate_i;
  logic [7:0] read_dly;
  logic [23:0] core_res, data;
  acms_pkg::acms_cmd_in_t cmd;
  int error_cnt, compares, n;

  acms_sequencer #(.POR_CYCLES(POR), .OSC_SPEEDUP(SPD)) dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .reset_pin_n_i(reset_pin_n_i), .cmd_i(cmd), .cfg_mode_i(cfg_mode_i), .cfg_rate_i(cfg_rate_i),
    .core_result_i(core_res), .result_latch_i(latch), .result_ready_n_o(rdy_n), .result_ready_oe_o(oe),
    .result_data_o(data), .cfg_defaults_o(dflt), .analog_on_o(aon), .converting_o(conv),
    .conversion_mode_sel_o(msel), .sleep_mode_o(slp));
  acms_host_model host (.sys_clk_i(sys_clk_i), .result_ready_n_i(rdy_n), .read_dly_i(read_dly),
    .cmd_o(cmd), .result_latch_o(latch));

  // oscillator periods to system cycles at the sped-up oscillator rate
  function automatic int cyc(input real p);
    return int'(p * `ACMS_SYS_CLK_KHZ / `ACMS_OSC_KHZ / SPD);
  endfunction

  task automatic tally_and_finish;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk_i);
    #1;
  endtask

  // cycles until ready falls; a hang ends the run
  task automatic wait_ready;
    n = 0;
    while (rdy_n !== 1'b0) begin
      tick(1);
      n++;
      if (n > 13000) begin
        error_cnt++;
        $display("MISMATCH ready fall expected 0 seen 1");
        tally_and_finish();
      end
    end
  endtask

  task automatic t_por;
    `CHK("defaults", 1'b1, dflt)
    `CHK("ready idle", 1'b1, rdy_n)
    n = 0;
    while (dflt === 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    `CHK("por length", 1'b1, n >= POR && n <= POR + 4)
    `CHK("idle after por", 1'b0, aon)
  endtask

  // command, general-call and pin resets abort a conversion; sleep, config write and wake
  task automatic t_cmds;
    for (int k = 0; k < 4; k++) begin
      host.send(8'h09, 1'b0, 1'b0);
      tick(1);
      `CHK("started", 1'b1, aon)
      if (k == 3) begin
        reset_pin_n_i = 1'b0;
        tick(1);
        reset_pin_n_i = 1'b1;
      end else begin
        host.send(k == 1 ? 8'h07 : 8'h06, k == 2, 1'b0);
      end
      tick(1);
      `CHK("reset idle", 1'b0, aon)
      tick(POR + 4);
    end
    host.send(8'h03, 1'b0, 1'b0);
    tick(1);
    `CHK("asleep", 1'b1, slp)
    host.send(8'h40, 1'b0, 1'b1);
    tick(3);
    `CHK("asleep no run", 1'b0, aon)
    `CHK("asleep kept", 1'b1, slp)
    host.send(8'h08, 1'b0, 1'b0);
    tick(1);
    `CHK("woken", 1'b0, slp)
    `CHK("woken run", 1'b1, aon)
    `CHK("woken mode", 1'b0, msel)
    host.send(8'h06, 1'b0, 1'b0);
    tick(POR + 4);
  endtask

  task automatic t_single;
    core_res = 24'h5A5A5A;
    host.send(8'h08, 1'b0, 1'b0);
    wait_ready();
    `CHK("single latency", 1'b1, n > cyc(1061) - 8 && n < cyc(1061) + 8)
    `CHK("single data", 24'h5A5A5A, data)
    `CHK("single off", 1'b0, aon)
    tick(12);
    `CHK("ready released", 1'b1, rdy_n)
    `CHK("data held", 24'h5A5A5A, data)
    // a config write mid-conversion starts one fresh single conversion at the new rate
    core_res = 24'hA5A5A5;
    cfg_rate_i = 2'h2;
    host.send(8'h08, 1'b0, 1'b0);
    tick(500);
    host.send(8'h40, 1'b0, 1'b1);
    wait_ready();
    `CHK("single restart", 1'b1, n > cyc(3141) - 8 && n < cyc(3141) + 8)
    `CHK("restart data", 24'hA5A5A5, data)
    `CHK("restart off", 1'b0, aon)
    cfg_rate_i = 2'h3;
    tick(12);
  endtask

  // continuous run: restart by config write, spacing, sleep lets run finish
  task automatic t_cont;
    cfg_mode_i = 1'b1;
    core_res = 24'h123456;
    read_dly = 8'h03;
    host.send(8'h08, 1'b0, 1'b0);
    tick(1000);
    host.send(8'h40, 1'b0, 1'b1);
    wait_ready();
    `CHK("restart time", 1'b1, n > cyc(1064.5) - 8 && n < cyc(1064.5) + 8)
    `CHK("cont data", 24'h123456, data)
    core_res = 24'h654321;
    host.send(8'h02, 1'b0, 1'b0);
    `CHK("runs on", 1'b1, aon)
    // ready must be read and released before the next fall can be timed; ten cycles passed since the fall
    tick(8);
    `CHK("cont released", 1'b1, rdy_n)
    wait_ready();
    `CHK("cont spacing", 1'b1, n + 10 > cyc(1036) - 8 && n + 10 < cyc(1036) + 8)
    `CHK("next data", 24'h654321, data)
    tick(3);
    `CHK("sleep after run", 1'b1, slp)
    `CHK("stopped", 1'b0, aon)
  endtask

  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  // reset, then the scenarios in turn
  initial begin
    reset_i = 1'b1;
    reset_pin_n_i = 1'b1;
    cfg_mode_i = 1'b0;
    cfg_rate_i = 2'h3;
    core_res = 24'h000000;
    read_dly = 8'h05;
    error_cnt = 0;
    compares = 0;
    tick(2);
    reset_i = 1'b0;
    t_por();
    t_cmds();
    t_single();
    t_cont();
    tally_and_finish();
  end
endmodule

bind acms_sequencer acms_sequencer_props #(.POR_CYCLES(POR_CYCLES)) u_props (.sys_clk_i(sys_clk_i),
  .reset_i(reset_i), .reset_pin_n_i(reset_pin_n_i), .cmd_i(cmd_i), .cfg_mode_i(cfg_mode_i),
  .cfg_rate_i(cfg_rate_i), .core_result_i(core_result_i), .result_latch_i(result_latch_i),
  .result_ready_n_o(result_ready_n_o), .result_ready_oe_o(result_ready_oe_o), .result_data_o(result_data_o),
  .cfg_defaults_o(cfg_defaults_o), .analog_on_o(analog_on_o), .converting_o(converting_o),
  .conversion_mode_sel_o(conversion_mode_sel_o), .sleep_mode_o(sleep_mode_o));
`default_nettype wire
